// ### include/csd_pkg.sv
package csd_pkg;

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;   // Control and polarity
  localparam logic [7:0] DLY_OFS  = 8'h04;   // Delay cell counts
  localparam logic [7:0] STAT_OFS = 8'h08;   // Live status

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CTRL_SEL_LSB  = 0;   // Warning delay select, 2 bits
  localparam int CTRL_CPOL_BIT = 2;   // Crash request active level
  localparam int CTRL_FPOL_BIT = 3;   // Force reset active level
  localparam int CTRL_UPEN_BIT = 4;   // Rising edge is delayed
  localparam int CTRL_DNEN_BIT = 5;   // Falling edge is delayed
  localparam int CTRL_CSEL_BIT = 6;   // Count clock: 0 hclk, 1 divider
  localparam int CTRL_SWR_BIT  = 7;   // Software reset request, write 1
  localparam int DLY_UP_LSB    = 0;   // Up count, 5 bits
  localparam int DLY_DN_LSB    = 8;   // Down count, 5 bits
  localparam int DLY_DIV_LSB   = 16;  // Divider reload, 8 bits

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0]  CTRL_RST = 8'h3c;
  localparam logic [23:0] DLY_RST  = 24'h000101;
  localparam logic [23:0] DLY_MASK = 24'hff1f1f;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ    = 125_000_000;
  localparam int unsigned MS_PER_S  = 1000;
  localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam logic [7:0]  WARN_MS_0 = 8'h0a;   // 10 ms
  localparam logic [7:0]  WARN_MS_1 = 8'h32;   // 50 ms
  localparam logic [7:0]  WARN_MS_2 = 8'h64;   // 100 ms
  localparam logic [7:0]  WARN_MS_3 = 8'hc8;   // 200 ms
  localparam logic [4:0]  CNT_MIN   = 5'h01;   // Least delay count

  // Crash unit states
  typedef enum logic [1:0] {CSD_RUN, CSD_WARN, CSD_OFF} csd_state_type;

endpackage

// ### verilog/csd_top.sv
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R01: Warning rises at once on any trigger
// R02: After selected ms delay, chip enters reset
// R03: Force input resets chip, skipping delay
// R04: Crash and force polarity are configurable
// R05: Separate up and down delays
// R06: Edge enables, delay setting, clock select
// R07: Delay count 1 to 31 clock periods
// R08: Prescaler counter extends delay range
// R09: One input drives both up and down
// R10: Input reverting restarts count, output kept
module csd_top #(
  parameter int unsigned MS_CYC = csd_pkg::MS_CYCLES   // Cycles per ms
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        crash_request,
  input  wire logic        force_reset,
  input  wire logic        cs_deassert,
  input  wire logic        over_temp,
  input  wire logic        crash_detect,
  input  wire logic        undervoltage_lockout,
  input  wire logic        delay_in,
  output logic             shutdown_warn,
  output logic             chip_reset,
  output logic             delay_out
);
  import csd_pkg::*;

  localparam logic [16:0] MS_LAST = 17'(MS_CYC - 1);

  // Level is active under the given polarity
  function automatic logic is_active(input logic lvl, input logic pol);
    is_active = (lvl == pol);
  endfunction

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  logic [7:0]  ctrl_r, ctrl_nxt;     // Control bits
  logic [23:0] dly_r, dly_nxt;       // Delay cell settings
  logic        swr_r, swr_nxt;       // Software reset pulse
  logic        wr_r, wr_nxt;         // Write data phase pending
  logic [7:0]  wa_r, wa_nxt;         // Write address
  logic [31:0] rd_r, rd_nxt;         // Read data
  logic [31:0] stat_w;               // Status word
  logic        aphase;               // Valid address phase

  assign aphase    = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rd_r;

  // Decode, write in data phase, read captured at address phase
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    dly_nxt  = dly_r;
    swr_nxt  = 1'b0;
    wr_nxt   = aphase & hwrite;
    wa_nxt   = haddr[7:0];
    rd_nxt   = rd_r;
    if (wr_r & (wa_r == CTRL_OFS))
    begin
      ctrl_nxt = {1'b0, hwdata[6:0]};
      swr_nxt  = hwdata[CTRL_SWR_BIT];
    end
    if (wr_r & (wa_r == DLY_OFS))
      dly_nxt = hwdata[23:0] & DLY_MASK;
    if (aphase & ~hwrite)
    begin
      unique case (haddr[7:0])
        CTRL_OFS: rd_nxt = {24'h000000, ctrl_r};
        DLY_OFS:  rd_nxt = {8'h00, dly_r};
        STAT_OFS: rd_nxt = stat_w;
        default:  rd_nxt = 32'h00000000;   // Unmapped reads zero
      endcase
    end
  end

  // Bus state registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_r <= CTRL_RST;
      dly_r  <= DLY_RST;
      swr_r  <= 1'b0;
      wr_r   <= 1'b0;
      wa_r   <= 8'h00;
      rd_r   <= 32'h00000000;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      dly_r  <= dly_nxt;
      swr_r  <= swr_nxt;
      wr_r   <= wr_nxt;
      wa_r   <= wa_nxt;
      rd_r   <= rd_nxt;
    end
  end

  // ------------------------------------------------------------
  // Crash sequence unit
  // ------------------------------------------------------------
  csd_state_type st_r, st_nxt;        // Unit state
  logic [16:0]   sub_r, sub_nxt;      // Cycles within a ms
  logic [7:0]    ms_r, ms_nxt;        // Elapsed ms
  logic [7:0]    tgt_r, tgt_nxt;      // Latched delay in ms
  logic          crash_act;           // Crash request active
  logic          force_act;           // Force reset active
  logic          trig;                // Any warning cause except force reset
  logic [7:0]    sel_ms;              // Selected delay

  assign crash_act = is_active(crash_request, ctrl_r[CTRL_CPOL_BIT]);  // [R04]
  assign force_act = is_active(force_reset, ctrl_r[CTRL_FPOL_BIT]);    // [R04]
  assign trig      = crash_act | cs_deassert | over_temp | crash_detect
                   | swr_r | undervoltage_lockout;
  // Warning is combinational so it follows the cause in the same cycle
  assign shutdown_warn = trig | force_act | (st_r != CSD_RUN);         // [R01]
  assign chip_reset    = force_act | (st_r == CSD_OFF);               // [R03]

  // Delay select decode
  always_comb
  begin
    unique case (ctrl_r[CTRL_SEL_LSB +: 2])
      2'b00: sel_ms = WARN_MS_0;
      2'b01: sel_ms = WARN_MS_1;
      2'b10: sel_ms = WARN_MS_2;
      2'b11: sel_ms = WARN_MS_3;
    endcase
  end

  // Next state: run, warn for the delay, then held off until reset
  always_comb
  begin
    st_nxt  = st_r;
    sub_nxt = sub_r;
    ms_nxt  = ms_r;
    tgt_nxt = tgt_r;
    unique case (st_r)
      CSD_RUN:
      begin
        sub_nxt = 17'h00000;
        ms_nxt  = 8'h00;
        if (force_act)
          st_nxt = CSD_OFF;                                   // [R03]
        else if (trig)
        begin
          st_nxt  = CSD_WARN;                                 // [R01]
          tgt_nxt = sel_ms;
        end
      end
      CSD_WARN:
      begin
        if (force_act)
          st_nxt = CSD_OFF;                                   // [R03]
        else if (sub_r == MS_LAST)
        begin
          sub_nxt = 17'h00000;
          ms_nxt  = ms_r + 8'h01;
          if (ms_r + 8'h01 == tgt_r)
            st_nxt = CSD_OFF;                                 // [R02]
        end
        else
          sub_nxt = sub_r + 17'h00001;
      end
      CSD_OFF:
        st_nxt = CSD_OFF;                                     // [R02]
      default: st_nxt = CSD_OFF;                              // Illegal code fails safe
    endcase
  end

  // Crash unit registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r  <= CSD_RUN;
      sub_r <= 17'h00000;
      ms_r  <= 8'h00;
      tgt_r <= WARN_MS_0;
    end
    else
    begin
      st_r  <= st_nxt;
      sub_r <= sub_nxt;
      ms_r  <= ms_nxt;
      tgt_r <= tgt_nxt;
    end
  end

  // ------------------------------------------------------------
  // Prescaler and delay cell
  // ------------------------------------------------------------
  logic [7:0] div_r, div_nxt;        // Prescaler count
  logic [4:0] cnt_r, cnt_nxt;        // Delay ticks counted
  logic       out_r, out_nxt;        // Delayed output
  logic       pre_tick;              // Prescaler wrap
  logic       tick;                  // Delay count clock
  logic       pend;                  // Input differs from output
  logic       rise;                  // Pending edge is rising
  logic       bypass;                // Edge not delayed
  logic [4:0] tgt_cnt;               // Count for pending edge

  assign pre_tick = (div_r == dly_r[DLY_DIV_LSB +: 8]);
  assign tick     = ctrl_r[CTRL_CSEL_BIT] ? pre_tick : 1'b1;   // [R08]
  assign pend     = (delay_in != out_r);                       // [R09]
  assign rise     = delay_in & ~out_r;
  assign bypass   = rise ? ~ctrl_r[CTRL_UPEN_BIT] : ~ctrl_r[CTRL_DNEN_BIT];
  assign delay_out = out_r;

  // Per edge count, zero treated as the least count
  always_comb
  begin
    tgt_cnt = rise ? dly_r[DLY_UP_LSB +: 5] : dly_r[DLY_DN_LSB +: 5];  // [R05]
    if (tgt_cnt < CNT_MIN)
      tgt_cnt = CNT_MIN;                                      // [R07]
  end

  // Next values of prescaler and delay cell
  always_comb
  begin
    div_nxt = pre_tick ? 8'h00 : div_r + 8'h01;
    cnt_nxt = cnt_r;
    out_nxt = out_r;
    if (chip_reset)
    begin
      cnt_nxt = 5'h00;
      out_nxt = 1'b0;
    end
    else if (!pend)
      cnt_nxt = 5'h00;                                        // [R10]
    else if (bypass)
    begin
      out_nxt = delay_in;                                     // [R06]
      cnt_nxt = 5'h00;
    end
    else if (tick)
    begin
      if (cnt_r + 5'h01 >= tgt_cnt)
      begin
        out_nxt = delay_in;                                   // [R07]
        cnt_nxt = 5'h00;
      end
      else
        cnt_nxt = cnt_r + 5'h01;
    end
  end

  // Delay cell registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_r <= 8'h00;
      cnt_r <= 5'h00;
      out_r <= 1'b0;
    end
    else
    begin
      div_r <= div_nxt;
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign stat_w = {27'h0000000, force_act, crash_act, out_r, chip_reset,
                   shutdown_warn};

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  logic [31:0] wcyc_r;   // Cycles spent in warning
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wcyc_r <= 32'h00000000;
    else if (st_r == CSD_WARN)
      wcyc_r <= wcyc_r + 32'h00000001;
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_warn_cause: assert property (trig |-> shutdown_warn ##1 (st_r != CSD_RUN))  // [R01]
    else $error("warning not raised by cause");
  a_warn_delay: assert property (                         // [R02]
    (st_r == CSD_WARN) && (st_nxt == CSD_OFF) && !force_act
    |-> (wcyc_r + 32'h1) == (32'(tgt_r) * MS_CYC))
    else $error("warning delay length wrong");
  a_off_sticky: assert property (                         // [R02]
    (st_r == CSD_OFF) |=> (st_r == CSD_OFF) && chip_reset)
    else $error("reset state left");
  a_force_now: assert property (                          // [R03]
    force_act |-> chip_reset ##1 (st_r == CSD_OFF))
    else $error("force did not reset");
  a_crash_pol: assert property (                          // [R04]
    (crash_request == ctrl_r[CTRL_CPOL_BIT]) |-> shutdown_warn ##1 (st_r != CSD_RUN))
    else $error("crash polarity ignored");
  a_dly_early: assert property (                          // [R07]
    pend && !bypass && !chip_reset && (cnt_r + 5'h01 < tgt_cnt)
    |=> $stable(out_r))
    else $error("delay output moved early");
  a_dly_bypass: assert property (                         // [R06]
    pend && bypass && !chip_reset |=> out_r == $past(delay_in))
    else $error("undelayed edge not passed");
  a_div_hold: assert property (                           // [R08]
    ctrl_r[CTRL_CSEL_BIT] && !pre_tick && pend && !bypass && !chip_reset
    |=> $stable(out_r) && $stable(cnt_r))
    else $error("count moved without divider tick");
  a_dly_restart: assert property (                        // [R10]
    !pend && !chip_reset |=> (cnt_r == 5'h00) && $stable(out_r))
    else $error("count not restarted");

  c_warn_off: cover property ((st_r == CSD_WARN) ##1 (st_r == CSD_OFF));
  c_force:    cover property ((st_r == CSD_RUN) && force_act);
  c_dly_rise: cover property (!out_r ##1 out_r);
  c_dly_fall: cover property (out_r ##1 !out_r);

endmodule

`default_nettype wire

// ### verification/csd_matrix_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Far side: interconnect matrix and rails
// ----------------------------------------
module csd_matrix_model (
  input  wire logic want_crash,   // Matrix asks for a crash
  input  wire logic crash_pol,    // Programmed active level
  input  wire logic rail_cmd,     // Common up/down request
  input  wire logic shutdown_warn,
  input  wire logic delay_out,
  output logic      crash_request,
  output logic      delay_in,
  output logic      rail_on       // Regulator enable
);
  // Request driven at the programmed level only
  assign crash_request = want_crash ? crash_pol : ~crash_pol;
  // One signal feeds both up and down edges
  assign delay_in = rail_cmd;
  // Rail follows delayed enable, drops on warning
  assign rail_on = delay_out & ~shutdown_warn;
endmodule
`default_nettype wire

// ### verification/test_crash_shutdown_and_updown_delay.sv
`timescale 1ns/1ps
`default_nettype none
module test_crash_shutdown_and_updown_delay;
  import csd_pkg::*;
  localparam int MSC = 10;   // Short millisecond for the run
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, force_reset;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [4:0]  cz;           // Cause bits, last one is crash request
  logic        crash_pol, rail_cmd, crash_request, delay_in;
  logic        shutdown_warn, chip_reset, delay_out;
  int          miscompares, n_compared, n, up, dn, dv;
  int          ms[4] = '{10, 50, 100, 200};
  csd_top #(.MS_CYC(MSC)) i_csd_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .crash_request(crash_request), .force_reset(force_reset), .cs_deassert(cz[0]),
    .over_temp(cz[1]), .crash_detect(cz[2]), .undervoltage_lockout(cz[3]),
    .delay_in(delay_in), .shutdown_warn(shutdown_warn), .chip_reset(chip_reset),
    .delay_out(delay_out));
  csd_matrix_model i_csd_matrix_model (.want_crash(cz[4]), .crash_pol(crash_pol),
    .rail_cmd(rail_cmd), .shutdown_warn(shutdown_warn), .delay_out(delay_out),
    .crash_request(crash_request), .delay_in(delay_in), .rail_on());
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Wait for hready at an edge, bounded
  task automatic rdy();
    int t;
    t = 0;
    do
    begin
      @(posedge hclk);
      t++;
    end while (hreadyout !== 1'b1 && t < 50);
    if (hreadyout !== 1'b1)
    begin
      miscompares++;
      test_done();
    end
  endtask
  // One single AHB-Lite transfer, data taken at the data edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    rdy();
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
    q = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask
  function automatic logic sig(input int k);
    return k == 0 ? shutdown_warn : k == 1 ? chip_reset : delay_out;
  endfunction
  // Count edges until a watched output reaches a level
  task automatic cnt(input int k, input logic v, input int lim, output int c);
    c = 0;
    #1;
    while (sig(k) !== v && c < lim)
    begin
      @(posedge hclk);
      #1;
      c++;
    end
    if (sig(k) !== v)
    begin
      miscompares++;
      test_done();
    end
    @(posedge hclk);
  endtask
  task automatic rst();
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
  endtask
  // Delay measurement of one edge of the shared input
  task automatic meas(input logic v, input int e);
    rail_cmd <= v;
    cnt(2, v, 4000, n);
    chk("delay", n, e);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {hresetn, hsel, hwrite, force_reset, rail_cmd, crash_pol} = 6'b000001;
    {haddr, hwdata, htrans, cz} = '0;
    miscompares = 0;
    n_compared = 0;
    void'($urandom(32'h4388));
    rst();
    bus(0, CTRL_OFS, 0);
    chk("ctrl", q, 32'h3c);
    bus(0, DLY_OFS, 0);
    chk("dly", q, 32'h101);
    bus(0, 8'h10, 0);
    chk("unmapped", q, 0);
    // Boundary and random counts for both edges
    for (int i = 0; i < 3; i++)
    begin
      up = i == 0 ? 1 : i == 1 ? 31 : $urandom_range(2, 30);
      dn = 32 - up;
      bus(1, DLY_OFS, up | (dn << 8));
      bus(0, DLY_OFS, 0);
      chk("dly rd", q, up | (dn << 8));
      meas(1, up);
      meas(0, dn);
    end
    // Return before expiry restarts, output held
    bus(1, DLY_OFS, 32'h0503);
    rail_cmd <= 1'b1;
    repeat (2) @(posedge hclk);
    rail_cmd <= 1'b0;
    repeat (5) @(posedge hclk);
    @(negedge hclk);
    chk("glitch", delay_out, 0);
    @(posedge hclk);
    meas(1, 3);
    // Rising edge passes undelayed when disabled
    bus(1, CTRL_OFS, 32'h2c);
    meas(0, 5);
    meas(1, 1);
    // Falling edge passes undelayed when disabled
    bus(1, CTRL_OFS, 32'h1c);
    meas(0, 1);
    // Prescaled count clock
    up = $urandom_range(1, 4);
    dv = $urandom_range(0, 7);
    bus(1, DLY_OFS, up | 32'h0100 | (dv << 16));
    bus(1, CTRL_OFS, 32'h7c);
    rail_cmd <= 1'b1;
    cnt(2, 1, 4000, n);
    chk("presc", n > (up - 1) * (dv + 1) && n <= up * (dv + 1) + 1, 1);
    // Each cause with one warning delay, all four delays covered
    for (int k = 0; k < 5; k++)
    begin
      rst();
      bus(1, CTRL_OFS, 32'h3c | (k % 4));
      cz <= 5'b1 << k;
      #1 chk("warn", shutdown_warn, 1);
      cnt(1, 1, 4000, n);
      chk("reset", n, ms[k % 4] * MSC + 1);
      chk("warn hold", shutdown_warn, 1);
      bus(0, STAT_OFS, 0);
      chk("stat", q, k == 4 ? 32'h0b : 32'h03);
      cz <= '0;
    end
    // Software reset request
    rst();
    bus(1, CTRL_OFS, 32'hbc);
    cnt(0, 1, 3, n);
    chk("sw warn", n, 0);
    cnt(1, 1, 200, n);
    chk("sw", n, ms[0] * MSC);
    // Crash request active low, level and polarity switched together
    rst();
    bus(1, CTRL_OFS, 32'h38);
    crash_pol <= 1'b0;
    @(negedge hclk);
    chk("idle", shutdown_warn, 0);
    @(posedge hclk);
    cz <= 5'h10;
    #1 chk("lowcrash", shutdown_warn, 1);
    // Force reset active low, no delay
    rst();
    crash_pol <= 1'b1;
    cz <= '0;
    bus(1, CTRL_OFS, 32'h34);
    force_reset <= 1'b1;
    #1 chk("force idle", chip_reset, 0);
    @(posedge hclk);
    force_reset <= 1'b0;
    #1 chk("force", chip_reset, 1);
    @(posedge hclk);
    force_reset <= 1'b1;
    #1 chk("force held", chip_reset, 1);
    @(posedge hclk);
    test_done();
  end
endmodule
`default_nettype wire
